// *** rtl/tcd_decoder.sv ***
// transfer control decoder: jump, call, return and interrupt execution
// Function
// - decode jump, call, return, interrupt, reserved
// - taken jump loads pointer from target
// - not taken: sequential fetch, pointer unchanged
// - call saves pointer before branching
// - return reloads pointer from store
// - no call tracking, no return error
// - halting interrupt asserts host request low
// - halt until host writes pointer
// - interrupt operand kept as service vector
// - on-the-fly sets status bit two, continues
// - phase field compared with latched lines
// - relative target adds signed 24-bit offset
// - relative only for jump and call
// - carry test alone decides condition
// - polarity bit selects branch sense
// - both compares must agree
// - data compare against first received byte
// - mask bits exclude bit positions
// - phase compare or atn in target
// - wait for new phase before compare
// - pointer becomes target plus four
`timescale 1ns/1ps
module tcd_decoder
  import tcd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // instruction from fetch unit
  input wire logic insn_valid,
  output logic insn_ready,
  input wire logic [tcd_pkg::TCD_WORD_W-1:0] insn_word,
  input wire logic [tcd_pkg::TCD_WORD_W-1:0] insn_operand,
  input wire logic ip_advance,
  // fetch request to fetch unit
  output logic fetch_req,
  output logic [tcd_pkg::TCD_WORD_W-1:0] fetch_addr,
  output logic [tcd_pkg::TCD_WORD_W-1:0] instr_ptr,
  // conditions
  input wire logic alu_carry,
  input wire logic initiator_mode,
  input wire logic atn_active,
  input wire logic [tcd_pkg::TCD_PHASE_W-1:0] latched_phase,
  input wire logic phase_unserviced,
  output logic phase_consumed,
  input wire logic [tcd_pkg::TCD_BYTE_W-1:0] first_received_byte,
  // host side
  input wire logic host_ip_wr,
  input wire logic [tcd_pkg::TCD_WORD_W-1:0] host_ip_data,
  input wire logic fly_clr,
  input wire logic illegal_clr,
  output logic irq_n,
  output logic [tcd_pkg::TCD_INTERRUPT_STATUS_W-1:0] interrupt_status,
  output logic [tcd_pkg::TCD_WORD_W-1:0] branch_operand_holder,
  output logic [tcd_pkg::TCD_WORD_W-1:0] return_addr,
  output logic halted,
  output logic illegal_op
);

  import tcd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // state and storage
  tcd_state_type state_ff;
  tcd_state_type nxt_state;
  logic [TCD_WORD_W-1:0] instr_ff;
  logic [TCD_WORD_W-1:0] holder_ff;
  logic [TCD_WORD_W-1:0] ip_ff;
  logic [TCD_WORD_W-1:0] ret_ff;
  logic [TCD_WORD_W-1:0] fetch_addr_ff;
  logic fetch_req_ff;
  logic irq_n_ff;
  logic fly_ff;
  logic illegal_ff;
  logic consumed_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // decode of the held instruction
  logic [TCD_OP_W-1:0] op_code;
  logic op_select_msb;
  logic op_select_mid;
  logic op_select_lsb;
  logic is_jump;
  logic is_call;
  logic is_ret;
  logic is_int;
  logic new_reserved;
  logic new_waits;
  logic cond_taken;
  logic [TCD_WORD_W-1:0] target;
  logic [TCD_WORD_W-1:0] next_ptr;
  logic exec_taken;
  logic int_halt;
  logic int_fly;
  logic accept;

  assign op_code = instr_ff[TCD_OP_HI:TCD_OP_LO];
  assign op_select_msb = op_code[2];
  assign op_select_mid = op_code[1];
  assign op_select_lsb = op_code[0];

  assign is_jump = ~op_select_msb & ~op_select_mid & ~op_select_lsb;
  assign is_call = ~op_select_msb & ~op_select_mid & op_select_lsb;
  assign is_ret = ~op_select_msb & op_select_mid & ~op_select_lsb;
  assign is_int = ~op_select_msb & op_select_mid & op_select_lsb;

  assign new_reserved = insn_word[TCD_OP_HI];

  // wait only when the wait bit is set and a phase or data compare is enabled without carry test
  assign new_waits = insn_word[TCD_WAIT_BIT] & ~insn_word[TCD_CARRY_BIT]
                     & (insn_word[TCD_CMPP_BIT] | insn_word[TCD_CMPD_BIT]);

  assign accept = insn_valid && (state_ff == TCD_IDLE) && !host_ip_wr;

  ////////////////////////////////////////////////////////////////////////////////
  // condition and target
  tcd_cond_eval u_cond
  (
    .carry_test (instr_ff[TCD_CARRY_BIT]),
    .cmp_data (instr_ff[TCD_CMPD_BIT]),
    .cmp_phase (instr_ff[TCD_CMPP_BIT]),
    .branch_on_true (instr_ff[TCD_POL_BIT]),
    .phase_field (instr_ff[TCD_PHASE_HI:TCD_PHASE_LO]),
    .cmp_mask (instr_ff[TCD_MASK_HI:TCD_MASK_LO]),
    .cmp_value (instr_ff[TCD_VAL_HI:TCD_VAL_LO]),
    .alu_carry (alu_carry),
    .initiator_mode (initiator_mode),
    .atn_active (atn_active),
    .latched_phase (latched_phase),
    .first_received_byte (first_received_byte),
    .taken (cond_taken)
  );

  tcd_target_calc u_target
  (
    .op_code (op_code),
    .relative (instr_ff[TCD_REL_BIT]),
    .operand (holder_ff),
    .instr_ptr (ip_ff),
    .return_addr (ret_ff),
    .target (target),
    .next_ptr (next_ptr)
  );

  assign exec_taken = (state_ff == TCD_EXEC) && cond_taken && !host_ip_wr;
  assign int_halt = exec_taken && is_int && !instr_ff[TCD_FLY_BIT];
  assign int_fly = exec_taken && is_int && instr_ff[TCD_FLY_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      TCD_IDLE:
      begin
        if (accept)
        begin
          if (new_reserved)
          begin
            nxt_state = TCD_HALT;
          end
          else if (new_waits)
          begin
            nxt_state = TCD_WAIT_PHASE;
          end
          else
          begin
            nxt_state = TCD_EXEC;
          end
        end
      end
      TCD_WAIT_PHASE:
      begin
        if (host_ip_wr)
        begin
          nxt_state = TCD_IDLE;
        end
        else if (phase_unserviced)
        begin
          nxt_state = TCD_EXEC;
        end
      end
      TCD_EXEC:
      begin
        if (int_halt)
        begin
          nxt_state = TCD_HALT;
        end
        else
        begin
          nxt_state = TCD_IDLE;
        end
      end
      TCD_HALT:
      begin
        if (host_ip_wr)
        begin
          nxt_state = TCD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_ff <= TCD_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // instruction and operand holders
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      instr_ff <= TCD_WORD_RST;
    end
    else if (accept)
    begin
      instr_ff <= insn_word;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      holder_ff <= TCD_WORD_RST;
    end
    else if (accept)
    begin
      holder_ff <= insn_operand;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // instruction pointer
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ip_ff <= TCD_IP_RST;
    end
    else if (host_ip_wr)
    begin
      ip_ff <= host_ip_data;
    end
    else if (exec_taken && (is_jump || is_call || is_ret))
    begin
      ip_ff <= next_ptr;
    end
    else if (ip_advance)
    begin
      ip_ff <= ip_ff + TCD_IP_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // return address store
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ret_ff <= TCD_WORD_RST;
    end
    else if (exec_taken && is_call)
    begin
      ret_ff <= ip_ff;
    end
  end
  // return uses the store whatever it holds

  ////////////////////////////////////////////////////////////////////////////////
  // fetch request
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      fetch_req_ff <= 1'b0;
      fetch_addr_ff <= TCD_WORD_RST;
    end
    else if (host_ip_wr && state_ff != TCD_IDLE)
    begin
      fetch_req_ff <= 1'b1;
      fetch_addr_ff <= host_ip_data;
    end
    else if (exec_taken && (is_jump || is_call || is_ret))
    begin
      fetch_req_ff <= 1'b1;
      fetch_addr_ff <= target;
    end
    else if (state_ff == TCD_EXEC && !int_halt)
    begin
      fetch_req_ff <= 1'b1;
      fetch_addr_ff <= ip_ff;
    end
    else
    begin
      fetch_req_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // phase consumption
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      consumed_ff <= 1'b0;
    end
    else
    begin
      consumed_ff <= (state_ff == TCD_WAIT_PHASE) && phase_unserviced && !host_ip_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // host interrupt and status flags
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      irq_n_ff <= 1'b1;
    end
    else if (int_halt || (accept && new_reserved))
    begin
      irq_n_ff <= 1'b0;
    end
    else if (host_ip_wr)
    begin
      irq_n_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      fly_ff <= 1'b0;
    end
    else if (int_fly)
    begin
      fly_ff <= 1'b1;
    end
    else if (fly_clr)
    begin
      fly_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      illegal_ff <= 1'b0;
    end
    else if (accept && new_reserved)
    begin
      illegal_ff <= 1'b1;
    end
    else if (illegal_clr)
    begin
      illegal_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign insn_ready = (state_ff == TCD_IDLE) && !host_ip_wr;
  assign fetch_req = fetch_req_ff;
  assign fetch_addr = fetch_addr_ff;
  assign instr_ptr = ip_ff;
  assign phase_consumed = consumed_ff;
  assign irq_n = irq_n_ff;
  assign branch_operand_holder = holder_ff;
  assign return_addr = ret_ff;
  assign halted = (state_ff == TCD_HALT);
  assign illegal_op = illegal_ff;

  always_comb
  begin
    interrupt_status = TCD_INTERRUPT_STATUS_RST;
    interrupt_status[TCD_INTERRUPT_STATUS_FLY_BIT] = fly_ff;
  end

endmodule

// *** rtl/tcd_pkg.sv ***
// package of field positions, codes, reset values and types for the transfer control decoder
package tcd_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int TCD_WORD_W = 32;
  localparam int TCD_OFFS_W = 24;
  localparam int TCD_OP_W = 3;
  localparam int TCD_PHASE_W = 3;
  localparam int TCD_BYTE_W = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // first longword field positions
  localparam int TCD_OP_HI = 29;
  localparam int TCD_OP_LO = 27;
  localparam int TCD_PHASE_HI = 26;
  localparam int TCD_PHASE_LO = 24;
  localparam int TCD_REL_BIT = 23;
  localparam int TCD_CARRY_BIT = 21;
  localparam int TCD_FLY_BIT = 20;
  localparam int TCD_POL_BIT = 19;
  localparam int TCD_CMPD_BIT = 18;
  localparam int TCD_CMPP_BIT = 17;
  localparam int TCD_WAIT_BIT = 16;
  localparam int TCD_MASK_HI = 15;
  localparam int TCD_MASK_LO = 8;
  localparam int TCD_VAL_HI = 7;
  localparam int TCD_VAL_LO = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // operation codes, the top bit marks reserved codes
  localparam logic [2:0] TCD_OP_JUMP = 3'h0;
  localparam logic [2:0] TCD_OP_CALL = 3'h1;
  localparam logic [2:0] TCD_OP_RET = 3'h2;
  localparam logic [2:0] TCD_OP_INT = 3'h3;
  localparam int TCD_OP_RSVD_BIT = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status layout and reset values
  localparam int TCD_INTERRUPT_STATUS_W = 8;
  localparam int TCD_INTERRUPT_STATUS_FLY_BIT = 2;
  localparam logic [31:0] TCD_IP_RST = 32'h0000_0000;
  localparam logic [31:0] TCD_WORD_RST = 32'h0000_0000;
  localparam logic [7:0] TCD_INTERRUPT_STATUS_RST = 8'h00;
  localparam logic [31:0] TCD_IP_STEP = 32'h0000_0004;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer states
  typedef enum logic [1:0] {
    TCD_IDLE,
    TCD_WAIT_PHASE,
    TCD_EXEC,
    TCD_HALT
  } tcd_state_type;

endpackage

// *** rtl/tcd_cond_eval.sv ***
// condition evaluation for branch-type instructions
`timescale 1ns/1ps
module tcd_cond_eval
  import tcd_pkg::*;
(
  // instruction condition fields
  input wire logic carry_test,
  input wire logic cmp_data,
  input wire logic cmp_phase,
  input wire logic branch_on_true,
  input wire logic [tcd_pkg::TCD_PHASE_W-1:0] phase_field,
  input wire logic [tcd_pkg::TCD_BYTE_W-1:0] cmp_mask,
  input wire logic [tcd_pkg::TCD_BYTE_W-1:0] cmp_value,
  // live conditions
  input wire logic alu_carry,
  input wire logic initiator_mode,
  input wire logic atn_active,
  input wire logic [tcd_pkg::TCD_PHASE_W-1:0] latched_phase,
  input wire logic [tcd_pkg::TCD_BYTE_W-1:0] first_received_byte,
  // result
  output logic taken
);

  logic phase_true;
  logic data_true;

  assign phase_true = initiator_mode ? (latched_phase == phase_field) : atn_active;
  assign data_true = (((first_received_byte ^ cmp_value) & ~cmp_mask) == '0);

  always_comb
  begin
    if (carry_test)
    begin
      taken = branch_on_true ? alu_carry : ~alu_carry;
    end
    else if (cmp_phase && cmp_data)
    begin
      taken = branch_on_true ? (phase_true & data_true) : (~phase_true & ~data_true);
    end
    else if (cmp_phase)
    begin
      taken = branch_on_true ? phase_true : ~phase_true;
    end
    else if (cmp_data)
    begin
      taken = branch_on_true ? data_true : ~data_true;
    end
    else
    begin
      // no test enabled counts as a true comparison
      taken = branch_on_true;
    end
  end

endmodule

// *** rtl/tcd_target_calc.sv ***
// branch target and follow-on pointer calculation
`timescale 1ns/1ps
module tcd_target_calc
  import tcd_pkg::*;
(
  // instruction
  input wire logic [tcd_pkg::TCD_OP_W-1:0] op_code,
  input wire logic relative,
  input wire logic [tcd_pkg::TCD_WORD_W-1:0] operand,
  // pointers
  input wire logic [tcd_pkg::TCD_WORD_W-1:0] instr_ptr,
  input wire logic [tcd_pkg::TCD_WORD_W-1:0] return_addr,
  // results
  output logic [tcd_pkg::TCD_WORD_W-1:0] target,
  output logic [tcd_pkg::TCD_WORD_W-1:0] next_ptr
);

  logic [TCD_WORD_W-1:0] offset_ext;
  logic use_rel;

  assign offset_ext = {{(TCD_WORD_W-TCD_OFFS_W){operand[TCD_OFFS_W-1]}}, operand[TCD_OFFS_W-1:0]};
  // relative for jump and call only
  assign use_rel = relative && ((op_code == TCD_OP_JUMP) || (op_code == TCD_OP_CALL));

  always_comb
  begin
    if (op_code == TCD_OP_RET)
    begin
      target = return_addr;
    end
    else if (use_rel)
    begin
      target = instr_ptr + offset_ext;
    end
    else
    begin
      target = operand;
    end
  end

  assign next_ptr = target + TCD_IP_STEP;

endmodule

// *** dv/tcd_decoder_assertions.sv ***
// port-level checker of the transfer control decoder
`timescale 1ns/1ps
module tcd_checker
  import tcd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // instruction and fetch
  input wire logic insn_valid,
  input wire logic insn_ready,
  input wire logic [tcd_pkg::TCD_WORD_W-1:0] insn_word,
  input wire logic [tcd_pkg::TCD_WORD_W-1:0] insn_operand,
  input wire logic fetch_req,
  input wire logic [tcd_pkg::TCD_WORD_W-1:0] fetch_addr,
  input wire logic [tcd_pkg::TCD_WORD_W-1:0] instr_ptr,
  // host side
  input wire logic host_ip_wr,
  input wire logic [tcd_pkg::TCD_WORD_W-1:0] host_ip_data,
  input wire logic irq_n,
  input wire logic [tcd_pkg::TCD_INTERRUPT_STATUS_W-1:0] interrupt_status,
  input wire logic [tcd_pkg::TCD_WORD_W-1:0] branch_operand_holder,
  input wire logic [tcd_pkg::TCD_WORD_W-1:0] return_addr,
  input wire logic halted,
  input wire logic illegal_op,
  // phase handshake
  input wire logic phase_unserviced,
  input wire logic phase_consumed
);
  logic accept;
  assign accept = insn_valid && insn_ready;
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  property p_fetch_ptr;
    fetch_req |-> (instr_ptr == fetch_addr) || (instr_ptr == fetch_addr + TCD_IP_STEP);
  endproperty
  a_fetch_ptr: assert property (p_fetch_ptr) else $error("pointer not fetch address or plus four");
  property p_irq_halt;
    !irq_n |-> halted;
  endproperty
  a_irq_halt: assert property (p_irq_halt) else $error("request low while running");
  property p_halt_hold;
    halted && !host_ip_wr |=> halted && !insn_ready;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("engine left halt without pointer write");
  property p_resume;
    halted && host_ip_wr |=> !halted && irq_n && fetch_req && fetch_addr == $past(host_ip_data);
  endproperty
  a_resume: assert property (p_resume) else $error("pointer write did not resume");
  property p_reserved;
    accept && insn_word[TCD_OP_HI] |=> illegal_op && halted && !irq_n;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code not trapped");
  property p_holder;
    accept |=> branch_operand_holder == $past(insn_operand);
  endproperty
  a_holder: assert property (p_holder) else $error("operand holder not loaded");
  property p_ret_quiet;
    accept && insn_word[29:27] == TCD_OP_RET && !insn_word[TCD_WAIT_BIT] |=> irq_n ##1 (irq_n && fetch_req);
  endproperty
  a_ret_quiet: assert property (p_ret_quiet) else $error("return raised a request");
  property p_call_save;
    $changed(return_addr) |-> return_addr == $past(instr_ptr);
  endproperty
  a_call_save: assert property (p_call_save) else $error("return store not old pointer");
  property p_fly;
    $rose(interrupt_status[TCD_INTERRUPT_STATUS_FLY_BIT]) |-> irq_n && !halted && fetch_req;
  endproperty
  a_fly: assert property (p_fly) else $error("on-the-fly interrupt halted");
  property p_answer;
    accept && !insn_word[TCD_WAIT_BIT] && !insn_word[TCD_OP_HI] |-> ##2 (fetch_req || !irq_n);
  endproperty
  a_answer: assert property (p_answer) else $error("no fetch two cycles after accept");
  property p_consume;
    phase_consumed |-> $past(phase_unserviced) && !fetch_req && !insn_ready;
  endproperty
  a_consume: assert property (p_consume) else $error("phase consumed without waiting compare");
  c_reserved: cover property (accept && insn_word[TCD_OP_HI]);
  c_fly: cover property ($rose(interrupt_status[TCD_INTERRUPT_STATUS_FLY_BIT]));
  c_call: cover property ($changed(return_addr));
endmodule
bind tcd_decoder tcd_checker u_chk (.clk_sys, .sys_rst, .insn_valid, .insn_ready, .insn_word, .insn_operand,
  .fetch_req, .fetch_addr, .instr_ptr, .host_ip_wr, .host_ip_data, .irq_n, .interrupt_status,
  .branch_operand_holder, .return_addr, .halted, .illegal_op, .phase_unserviced, .phase_consumed);

// *** dv/tcd_far_model.sv ***
// far side model: scsi phase source and interrupt-servicing host
`timescale 1ns/1ps
module tcd_far_model
  import tcd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // scsi phase source
  input wire logic phase_consumed,
  output logic phase_unserviced,
  // host processor
  input wire logic irq_n,
  input wire logic illegal_op,
  input wire logic [tcd_pkg::TCD_INTERRUPT_STATUS_W-1:0] interrupt_status,
  input wire logic [tcd_pkg::TCD_WORD_W-1:0] resume_addr,
  output logic host_ip_wr,
  output logic [tcd_pkg::TCD_WORD_W-1:0] host_ip_data,
  output logic fly_clr,
  output logic illegal_clr
);
  logic [3:0] tick_ff;
  ////////////////////////////////////////////////////////////////////////////////
  // new phases arrive every fourth cycle
  always_ff @(posedge clk_sys)
  begin
    tick_ff <= sys_rst ? 4'h0 : tick_ff + 4'h1;
    if (sys_rst || phase_consumed)
      phase_unserviced <= 1'h0;
    else if (tick_ff[1:0] == 2'h3)
      phase_unserviced <= 1'h1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // host pointer write
  always_ff @(posedge clk_sys)
  begin
    host_ip_wr <= 1'h0;
    illegal_clr <= 1'h0;
    host_ip_data <= sys_rst ? 32'h0000_0000 : ~host_ip_data;
    fly_clr <= interrupt_status[TCD_INTERRUPT_STATUS_FLY_BIT] && !fly_clr;
    if (!sys_rst && !irq_n && !host_ip_wr && tick_ff[2:0] == 3'h5)
    begin
      host_ip_wr <= 1'h1;
      host_ip_data <= resume_addr;
      illegal_clr <= illegal_op;
    end
  end
endmodule

// *** dv/tb_transfer_control_decoder.sv ***
// self-checking bench of the transfer control decoder
`timescale 1ns/1ps
module tb_transfer_control_decoder;
  import tcd_pkg::*;
  typedef struct packed {logic [31:0] addr; logic [31:0] ip; logic fly;} tcd_note_type;
  logic clk_sys, sys_rst, insn_valid, insn_ready, ip_advance, fetch_req, alu_carry, initiator_mode;
  logic atn_active, phase_unserviced, phase_consumed, host_ip_wr, fly_clr, illegal_clr, irq_n, halted, illegal_op;
  logic [31:0] insn_word, insn_operand, fetch_addr, instr_ptr, host_ip_data, branch_operand_holder, return_addr;
  logic [31:0] resume_addr, exp_ip, exp_ra, w;
  logic [2:0] latched_phase;
  logic [7:0] first_received_byte, interrupt_status;
  logic [31:0] dir_w [10] = '{32'h9008_0000, 32'h8808_0100, 32'h9008_0000, 32'h8088_0000, 32'h8888_0000,
    32'h800C_7F80, 32'h800B_0000, 32'h8028_0000, 32'h9818_0000, 32'hA000_0000};
  logic [31:0] dir_o [10] = '{32'h0000_0000, 32'h0000_0100, 32'h0000_0000, 32'h00FF_FFF0, 32'h00FF_FF00,
    32'h0000_0400, 32'h0000_0800, 32'h0000_0C00, 32'h0000_0000, 32'h0000_0000};
  int seed = 74;
  int miscompares = 0;
  int n_checks = 0;
  tcd_note_type q[$];
  tcd_note_type mn;
  tcd_decoder u_dut (.clk_sys, .sys_rst, .insn_valid, .insn_ready, .insn_word, .insn_operand, .ip_advance,
    .fetch_req, .fetch_addr, .instr_ptr, .alu_carry, .initiator_mode, .atn_active, .latched_phase,
    .phase_unserviced, .phase_consumed, .first_received_byte, .host_ip_wr, .host_ip_data, .fly_clr,
    .illegal_clr, .irq_n, .interrupt_status, .branch_operand_holder, .return_addr, .halted, .illegal_op);
  tcd_far_model u_far (.clk_sys, .sys_rst, .phase_consumed, .phase_unserviced, .irq_n, .illegal_op,
    .interrupt_status, .resume_addr, .host_ip_wr, .host_ip_data, .fly_clr, .illegal_clr);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [64:0] got, input logic [64:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic taken_of(logic [31:0] v, logic cy, logic ini, logic atn, logic [2:0] ph, logic [7:0] fb);
    logic p, d, c;
    p = ini ? (ph == v[26:24]) : atn;
    d = ((fb ^ v[7:0]) & ~v[15:8]) == 8'h00;
    c = v[21] ? cy : v[18] ? d : v[17] ? p : 1'h1;
    if (!v[21] && v[18] && v[17])
      c = v[19] ? (p && d) : (p || d);
    return c == v[19];
  endfunction
  // present one instruction with random conditions and note its outcome
  task automatic send(input logic [31:0] w_in, input logic [31:0] opd);
    logic [31:0] v, res;
    logic [2:0] r, ph;
    logic [7:0] fb;
    tcd_note_type n;
    logic adv;
    r = $random(seed);
    adv = $random(seed);
    if (adv) exp_ip = exp_ip + TCD_IP_STEP;
    ph = $random(seed);
    fb = $random(seed);
    res = $random(seed) & 32'hFFFF_FFFC;
    v = w_in;
    if (v[21]) v[18:17] = 2'h0;
    if (!r[1]) v[26:24] = 3'h0;
    n = '{exp_ip, exp_ip, 1'h0};
    if (v[29] || (v[29:27] == TCD_OP_INT && !v[20] && taken_of(v, r[0], r[1], r[2], ph, fb)))
    begin
      n = '{res, res, 1'h0};
      exp_ip = res;
    end
    else if (v[29:27] == TCD_OP_INT)
      n.fly = taken_of(v, r[0], r[1], r[2], ph, fb);
    else if (taken_of(v, r[0], r[1], r[2], ph, fb))
    begin
      n.addr = (v[29:27] == TCD_OP_RET) ? exp_ra : v[23] ? exp_ip + {{8{opd[23]}}, opd[23:0]} : opd;
      if (v[29:27] == TCD_OP_CALL) exp_ra = exp_ip;
      n.ip = n.addr + TCD_IP_STEP;
      exp_ip = n.ip;
    end
    q.push_back(n);
    do @(negedge clk_sys); while (insn_ready !== 1'h1);
    @(posedge clk_sys);
    {atn_active, initiator_mode, alu_carry} <= r;
    ip_advance <= adv;
    latched_phase <= ph;
    first_received_byte <= fb;
    resume_addr <= res;
    insn_valid <= 1'h1;
    insn_word <= v;
    insn_operand <= opd;
    @(posedge clk_sys);
    insn_valid <= 1'h0;
    ip_advance <= 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys)
  begin
    if (!sys_rst && fetch_req === 1'h1)
    begin
      mn = (q.size() > 0) ? q.pop_front() : '1;
      check({fetch_addr, instr_ptr, interrupt_status[TCD_INTERRUPT_STATUS_FLY_BIT]}, mn);
    end
  end
  initial
  begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    #2_000_000;
    miscompares++;
    complete_run;
  end
  initial
  begin
    {sys_rst, insn_valid, ip_advance, alu_carry, initiator_mode, atn_active} = 6'h20;
    {insn_word, insn_operand, resume_addr, exp_ip, exp_ra} = '0;
    latched_phase = 3'h0;
    first_received_byte = 8'h00;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'h0;
    for (int i = 0; i < 10; i++)
      send(dir_w[i], dir_o[i]);
    for (int i = 0; i < 200; i++)
    begin
      w = $random(seed);
      w[31:30] = 2'h2;
      w[22] = 1'h0;
      send(w, $random(seed));
    end
    repeat (60) @(posedge clk_sys);
    check(65'(q.size()), 65'h0);
    complete_run;
  end
endmodule
